// ### regulator_ctl_pkg.sv
// Purpose: shared constants and types for the regulator control page regs
// Assumes: 8-bit register map, address and data, behind a register port
// Notes:   index 0 is the 3.3 V rail, 1 and 2 the linear regulators
package regulator_ctl_pkg;

  localparam int NUM_RAILS = 3;

  // register addresses, index 0 rail33, 1 linreg3, 2 linreg4
  localparam logic [NUM_RAILS-1:0][7:0] CTL_ADDR = {8'h71, 8'h70, 8'h6f};
  localparam logic [7:0] PAGE_SEL_ADDR = 8'h7f;
  localparam int         EXT_ADDR_BIT  = 7;

  // control register field positions
  localparam int OFF_SLEEP_BIT = 7;
  localparam int LOWPOWER_BIT  = 6;
  localparam int STANDBY_BIT   = 5;
  localparam int ON_BIT        = 4;
  localparam int CODE_W        = 4;

  // writable bits; rail33 bits 3:2 are reserved
  localparam logic [NUM_RAILS-1:0][7:0] CTL_WMASK = {8'hff, 8'hff, 8'hf3};
  localparam logic [7:0] PAGE_WMASK      = 8'h0f;
  localparam logic [3:0] PAGE_RESET      = 4'h0;
  localparam logic [2:0] CTL_FIXED_RESET = 3'h0;
  localparam logic [7:0] CTL_RESET       = 8'h00;
  localparam logic [7:0] UNMAPPED_DATA   = 8'h00;

  // page field encodings
  localparam logic [3:0] PAGE_FUNC = 4'h0;
  localparam logic [3:0] PAGE_EXT1 = 4'h1;
  localparam logic [3:0] PAGE_EXT2 = 4'h2;

  typedef enum logic [1:0] {
    PG_FUNCTIONAL,
    PG_EXTENDED1,
    PG_EXTENDED2,
    PG_UNDEFINED
  } page_kind_type;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [7:0]        addr;
    logic [7:0]        wdata;
  } reg_req_type;

  typedef struct packed {
    logic              valid;
    logic [7:0]        data;
  } reg_rsp_type;

  typedef struct packed {
    logic [NUM_RAILS-1:0]             on;
    logic [NUM_RAILS-1:0][CODE_W-1:0] code;
  } fuse_cfg_type;

  typedef struct packed {
    logic              en;
    logic              sleep;
    logic              lowpower;
    logic [CODE_W-1:0] volt_code;
  } rail_out_type;

  typedef struct packed {
    logic              turnoff;
    logic              standby;
    logic              lp_req;
  } pin_sync_type;

  typedef struct packed {
    logic                             loaded;
    pin_sync_type                     sync1;
    pin_sync_type                     sync2;
    logic [NUM_RAILS-1:0][7:0]        ctl;
    logic [3:0]                       page;
    page_kind_type                    page_kind;
    reg_rsp_type                      rsp;
    rail_out_type [NUM_RAILS-1:0]     rail;
  } state_type;

endpackage

// ### regulator_ctl_page_regs.sv
// Purpose: control registers of three rails plus page select, with rail
//          on/sleep/low-power decisions driven out to the analog side
// Assumes: register port driven by the bus engine on clk_sys; fuse values
//          stable from the bus side's clock; control pins are asynchronous
// Notes:   fuse defaults are caught on the first edge after reset release
`timescale 1ns/1ns
module regulator_ctl_page_regs (
  // clock and reset
  input  wire logic                                    clk_sys,
  input  wire logic                                    rst_b,
  // register port
  input  wire regulator_ctl_pkg::reg_req_type          reg_req,
  output      regulator_ctl_pkg::reg_rsp_type          reg_rsp,
  // fuse configuration
  input  wire regulator_ctl_pkg::fuse_cfg_type         fuse_cfg,
  // mode pins
  input  wire logic                                    power_turnoff_event,
  input  wire logic                                    standby_req,
  input  wire logic                                    lowpower_req,
  // regulator controls
  output      regulator_ctl_pkg::rail_out_type [2:0]   rail_out,
  output      logic [3:0]                              page_sel,
  output      regulator_ctl_pkg::page_kind_type        page_kind
);

  regulator_ctl_pkg::state_type s_r;
  regulator_ctl_pkg::state_type s_nxt;

  // address to control register index; hit low when not a control reg
  function automatic logic [2:0] ctl_lookup(input logic [7:0] addr);
    logic [2:0] res;
    res = 3'h0;
    for (int i = 0; i < regulator_ctl_pkg::NUM_RAILS; i++) begin
      if (addr == regulator_ctl_pkg::CTL_ADDR[i]) begin
        res = {1'b1, i[1:0]};
      end
    end
    return res;
  endfunction

  function automatic regulator_ctl_pkg::page_kind_type decode_page(
    input logic [3:0] pg
  );
    regulator_ctl_pkg::page_kind_type k;
    case (pg)
      regulator_ctl_pkg::PAGE_FUNC: k = regulator_ctl_pkg::PG_FUNCTIONAL;
      regulator_ctl_pkg::PAGE_EXT1: k = regulator_ctl_pkg::PG_EXTENDED1;
      regulator_ctl_pkg::PAGE_EXT2: k = regulator_ctl_pkg::PG_EXTENDED2;
      default:                      k = regulator_ctl_pkg::PG_UNDEFINED;
    endcase
    return k;
  endfunction

  always_comb begin
    logic [2:0] wr_hit;
    logic [2:0] rd_hit;
    logic [7:0] c;
    wr_hit = ctl_lookup(reg_req.addr);
    rd_hit = wr_hit;
    c      = 8'h00;
    s_nxt  = s_r;

    // pin synchronisers
    s_nxt.sync1.turnoff = power_turnoff_event;
    s_nxt.sync1.standby = standby_req;
    s_nxt.sync1.lp_req  = lowpower_req;
    s_nxt.sync2         = s_r.sync1;

    // register writes; fuse load takes the first cycle
    if (!s_r.loaded) begin
      s_nxt.loaded = 1'b1;
      for (int i = 0; i < regulator_ctl_pkg::NUM_RAILS; i++) begin
        s_nxt.ctl[i] = {regulator_ctl_pkg::CTL_FIXED_RESET,
                        fuse_cfg.on[i], fuse_cfg.code[i]}
                       & regulator_ctl_pkg::CTL_WMASK[i];
      end
    end else if (reg_req.wr) begin
      if (reg_req.addr[regulator_ctl_pkg::EXT_ADDR_BIT]) begin
        // no extended registers on any page: write dropped
        s_nxt.page = s_r.page;
      end else if (reg_req.addr == regulator_ctl_pkg::PAGE_SEL_ADDR) begin
        s_nxt.page = 4'(reg_req.wdata
                        & regulator_ctl_pkg::PAGE_WMASK);
      end else if (wr_hit[2]) begin
        s_nxt.ctl[wr_hit[1:0]] = reg_req.wdata
          & regulator_ctl_pkg::CTL_WMASK[wr_hit[1:0]];
      end
    end
    s_nxt.page_kind = decode_page(s_r.page);

    // register reads, answered one cycle later
    s_nxt.rsp.valid = reg_req.rd;
    s_nxt.rsp.data  = regulator_ctl_pkg::UNMAPPED_DATA;
    if (reg_req.rd) begin
      if (reg_req.addr[regulator_ctl_pkg::EXT_ADDR_BIT]) begin
        s_nxt.rsp.data = regulator_ctl_pkg::UNMAPPED_DATA;
      end else if (reg_req.addr == regulator_ctl_pkg::PAGE_SEL_ADDR) begin
        s_nxt.rsp.data = {4'h0, s_r.page};
      end else if (rd_hit[2]) begin
        s_nxt.rsp.data = s_r.ctl[rd_hit[1:0]];
      end
    end

    // rail decisions from control bits and synchronised pins
    for (int i = 0; i < regulator_ctl_pkg::NUM_RAILS; i++) begin
      c = s_r.ctl[i];
      s_nxt.rail[i].en = c[regulator_ctl_pkg::ON_BIT]
        & !s_r.sync2.turnoff
        & !(s_r.sync2.standby
            & c[regulator_ctl_pkg::STANDBY_BIT]);
      s_nxt.rail[i].sleep = c[regulator_ctl_pkg::ON_BIT]
        & s_r.sync2.turnoff
        & c[regulator_ctl_pkg::OFF_SLEEP_BIT];
      s_nxt.rail[i].lowpower = s_nxt.rail[i].en
        & s_r.sync2.lp_req
        & c[regulator_ctl_pkg::LOWPOWER_BIT];
      s_nxt.rail[i].volt_code = c[regulator_ctl_pkg::CODE_W-1:0]
        & regulator_ctl_pkg::CTL_WMASK[i][3:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_r           <= '0;
      s_r.page      <= regulator_ctl_pkg::PAGE_RESET;
      s_r.page_kind <= regulator_ctl_pkg::PG_FUNCTIONAL;
      for (int i = 0; i < regulator_ctl_pkg::NUM_RAILS; i++) begin
        s_r.ctl[i]  <= regulator_ctl_pkg::CTL_RESET;
      end
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rsp   = s_r.rsp;
  assign rail_out  = s_r.rail;
  assign page_sel  = s_r.page;
  assign page_kind = s_r.page_kind;

  // checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  genvar g;
  generate
    for (g = 0; g < regulator_ctl_pkg::NUM_RAILS; g++) begin : g_rail_chk
      property p_sleep_on_event;
        s_r.sync2.turnoff && s_r.ctl[g][7] && s_r.ctl[g][4]
          |=> rail_out[g].sleep && !rail_out[g].en;
      endproperty
      a_sleep_on_event: assert property (p_sleep_on_event)
        else $error("rail not in sleep after turn-off event");

      property p_off_on_event;
        s_r.sync2.turnoff && !s_r.ctl[g][7]
          |=> !rail_out[g].sleep && !rail_out[g].en;
      endproperty
      a_off_on_event: assert property (p_off_on_event)
        else $error("rail not off after turn-off event");

      property p_lowpower_gate;
        !s_r.ctl[g][6] |=> !rail_out[g].lowpower;
      endproperty
      a_lowpower_gate: assert property (p_lowpower_gate)
        else $error("low power entered while not allowed");

      property p_standby_off;
        s_r.sync2.standby && !s_r.sync2.turnoff && s_r.ctl[g][4]
          |=> rail_out[g].en == !$past(s_r.ctl[g][5]);
      endproperty
      a_standby_off: assert property (p_standby_off)
        else $error("standby on/off choice not followed");

      property p_enable_bit;
        !s_r.sync2.turnoff && !s_r.sync2.standby
          |=> rail_out[g].en == $past(s_r.ctl[g][4]);
      endproperty
      a_enable_bit: assert property (p_enable_bit)
        else $error("rail enable does not follow its bit");

      property p_volt_code;
        s_r.loaded |=> rail_out[g].volt_code ==
          $past(s_r.ctl[g][3:0] & regulator_ctl_pkg::CTL_WMASK[g][3:0]);
      endproperty
      a_volt_code: assert property (p_volt_code)
        else $error("voltage code not driven from register");

      property p_fuse_load;
        $rose(s_r.loaded) |-> s_r.ctl[g][7:5] == 3'h0;
      endproperty
      a_fuse_load: assert property (p_fuse_load)
        else $error("fixed bits not zero after fuse load");

      property p_ctl_write;
        s_r.loaded && reg_req.wr
          && reg_req.addr == regulator_ctl_pkg::CTL_ADDR[g]
          |=> s_r.ctl[g] == ($past(reg_req.wdata)
                             & regulator_ctl_pkg::CTL_WMASK[g]);
      endproperty
      a_ctl_write: assert property (p_ctl_write)
        else $error("control write not stored with mask");

      property p_ctl_read;
        reg_req.rd && reg_req.addr == regulator_ctl_pkg::CTL_ADDR[g]
          |=> reg_rsp.valid && reg_rsp.data == $past(s_r.ctl[g]);
      endproperty
      a_ctl_read: assert property (p_ctl_read)
        else $error("control register read back wrong");

      property p_en_bit_low;
        !s_r.ctl[g][4] |=> !rail_out[g].en;
      endproperty
      a_en_bit_low: assert property (p_en_bit_low)
        else $error("rail enabled while its enable bit is clear");

      property p_fuse_values;
        $rose(s_r.loaded) |-> s_r.ctl[g][4] == $past(fuse_cfg.on[g])
          && s_r.ctl[g][3:0] == ($past(fuse_cfg.code[g])
                                 & regulator_ctl_pkg::CTL_WMASK[g][3:0]);
      endproperty
      a_fuse_values: assert property (p_fuse_values)
        else $error("enable or voltage code not loaded from fuses");
    end
  endgenerate

  property p_page_write;
    s_r.loaded && reg_req.wr && reg_req.addr == regulator_ctl_pkg::PAGE_SEL_ADDR
      |=> page_sel == $past(reg_req.wdata[3:0])
          ##1 page_kind == decode_page($past(page_sel));
  endproperty
  a_page_write: assert property (p_page_write)
    else $error("page write or page decode wrong");

  property p_ext_read;
    reg_req.rd && reg_req.addr[7]
      |=> reg_rsp.valid && reg_rsp.data == 8'h00;
  endproperty
  a_ext_read: assert property (p_ext_read)
    else $error("extended or unmapped read not zero");

  property p_ext_write;
    reg_req.wr && reg_req.addr[7] |=> $stable(s_r.ctl) && $stable(page_sel);
  endproperty
  a_ext_write: assert property (p_ext_write)
    else $error("write to unmapped address changed state");

  property p_page_read;
    reg_req.rd && reg_req.addr == regulator_ctl_pkg::PAGE_SEL_ADDR
      |=> reg_rsp.data[7:4] == 4'h0 && reg_rsp.data[3:0] == $past(page_sel);
  endproperty
  a_page_read: assert property (p_page_read)
    else $error("page read back wrong");

  property p_rail33_reserved;
    s_r.ctl[0][3:2] == 2'h0 && rail_out[0].volt_code[3:2] == 2'h0;
  endproperty
  a_rail33_reserved: assert property (p_rail33_reserved)
    else $error("reserved rail33 code bits not zero");

  // functional addresses that hold no register
  property p_unmapped_read;
    reg_req.rd && !reg_req.addr[7]
      && reg_req.addr != regulator_ctl_pkg::PAGE_SEL_ADDR
      && reg_req.addr != regulator_ctl_pkg::CTL_ADDR[0]
      && reg_req.addr != regulator_ctl_pkg::CTL_ADDR[1]
      && reg_req.addr != regulator_ctl_pkg::CTL_ADDR[2]
      |=> reg_rsp.valid && reg_rsp.data == 8'h00;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("unmapped functional read not zero");

  property p_unmapped_write;
    reg_req.wr && s_r.loaded && !reg_req.addr[7]
      && reg_req.addr != regulator_ctl_pkg::PAGE_SEL_ADDR
      && reg_req.addr != regulator_ctl_pkg::CTL_ADDR[0]
      && reg_req.addr != regulator_ctl_pkg::CTL_ADDR[1]
      && reg_req.addr != regulator_ctl_pkg::CTL_ADDR[2]
      |=> $stable(s_r.ctl) && $stable(page_sel);
  endproperty
  a_unmapped_write: assert property (p_unmapped_write)
    else $error("write to unmapped functional address changed state");

  // page decode, one code at a time
  property p_kind_func;
    page_sel == regulator_ctl_pkg::PAGE_FUNC
      |=> page_kind == regulator_ctl_pkg::PG_FUNCTIONAL;
  endproperty
  a_kind_func: assert property (p_kind_func)
    else $error("page code 0 not decoded as functional");

  property p_kind_ext1;
    page_sel == regulator_ctl_pkg::PAGE_EXT1
      |=> page_kind == regulator_ctl_pkg::PG_EXTENDED1;
  endproperty
  a_kind_ext1: assert property (p_kind_ext1)
    else $error("page code 1 not decoded as extended one");

  property p_kind_ext2;
    page_sel == regulator_ctl_pkg::PAGE_EXT2
      |=> page_kind == regulator_ctl_pkg::PG_EXTENDED2;
  endproperty
  a_kind_ext2: assert property (p_kind_ext2)
    else $error("page code 2 not decoded as extended two");

  c_sleep:    cover property (rail_out[0].sleep);
  c_lowpower: cover property (rail_out[1].lowpower);
  c_ext1:     cover property (page_kind == regulator_ctl_pkg::PG_EXTENDED1);
  c_ext2:     cover property (page_kind == regulator_ctl_pkg::PG_EXTENDED2);
  c_standby:  cover property (s_r.sync2.standby ##1 !rail_out[2].en);

endmodule

// ### reg_host_model.sv
// Purpose: host side of the register port, single-byte reads and writes
// Assumes: requests launched just after a rising edge, held one cycle
// Notes:   idle address shows the inverse of the last request; idle data is inverted at each release
`timescale 1ns/1ns
module reg_host_model (
  // clock
  input  wire logic                           clk_sys,
  // register port
  output      regulator_ctl_pkg::reg_req_type reg_req,
  input  wire regulator_ctl_pkg::reg_rsp_type reg_rsp
);
  initial begin
    reg_req = '0;
  end

  // released lines must not keep the old value
  task automatic release_req();
    reg_req.wr    <= 1'b0;
    reg_req.rd    <= 1'b0;
    reg_req.addr  <= ~reg_req.addr;
    reg_req.wdata <= ~reg_req.wdata;
  endtask

  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_req.wr    <= 1'b1;
    reg_req.addr  <= a;
    reg_req.wdata <= d;
    @(posedge clk_sys);
    release_req();
  endtask

  task automatic read_reg(input logic [7:0] a, output logic [7:0] d,
                          output logic v);
    @(posedge clk_sys);
    reg_req.rd   <= 1'b1;
    reg_req.addr <= a;
    @(posedge clk_sys);
    release_req();
    #1;
    v = reg_rsp.valid;
    d = reg_rsp.data;
  endtask
endmodule

// ### regulator_ctl_page_regs_tb_top.sv
// Purpose: self-checking bench for the regulator control page registers
// Assumes: fuse defaults held steady from reset onwards
// Notes:   rail outputs are sampled five edges after each pin change
`timescale 1ns/1ns
module regulator_ctl_page_regs_tb_top;
  localparam int MAX_CYCLES = 4000;
  logic                                  clk_sys;
  logic                                  rst_b;
  regulator_ctl_pkg::reg_req_type        reg_req;
  regulator_ctl_pkg::reg_rsp_type        reg_rsp;
  regulator_ctl_pkg::fuse_cfg_type       fuse_cfg;
  logic                                  power_turnoff_event;
  logic                                  standby_req;
  logic                                  lowpower_req;
  regulator_ctl_pkg::rail_out_type [2:0] rail_out;
  logic [3:0]                            page_sel;
  regulator_ctl_pkg::page_kind_type      page_kind;
  int                                    errors;
  int                                    total_checks;
  int                                    cycles;

  regulator_ctl_page_regs DUT (
    .clk_sys(clk_sys), .rst_b(rst_b), .reg_req(reg_req), .reg_rsp(reg_rsp),
    .fuse_cfg(fuse_cfg), .power_turnoff_event(power_turnoff_event),
    .standby_req(standby_req), .lowpower_req(lowpower_req),
    .rail_out(rail_out), .page_sel(page_sel), .page_kind(page_kind)
  );

  reg_host_model u_host (
    .clk_sys(clk_sys), .reg_req(reg_req), .reg_rsp(reg_rsp)
  );

  task automatic print_verdict();
    if (errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] seen);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       v;
    u_host.read_reg(a, d, v);
    check("read valid", 8'h01, {7'h0, v});
    check($sformatf("read %h", a), exp, d);
  endtask

  task automatic t_reset();
    rd_check(regulator_ctl_pkg::CTL_ADDR[0], 8'h13);
    rd_check(regulator_ctl_pkg::CTL_ADDR[1], 8'h06);
    rd_check(regulator_ctl_pkg::CTL_ADDR[2], 8'h19);
    rd_check(regulator_ctl_pkg::PAGE_SEL_ADDR, 8'h00);
    check("code0", 8'h03, {4'h0, rail_out[0].volt_code});
    check("en1", 8'h00, {7'h0, rail_out[1].en});
    check("en2", 8'h01, {7'h0, rail_out[2].en});
  endtask

  task automatic t_mask();
    logic [7:0] a [6];
    logic [7:0] x [6];
    a = '{regulator_ctl_pkg::CTL_ADDR[0], regulator_ctl_pkg::CTL_ADDR[1],
          regulator_ctl_pkg::CTL_ADDR[2], 8'h7f, 8'h6e, 8'h80};
    x = '{8'hf3, 8'hff, 8'hff, 8'h0f, 8'h00, 8'h00};
    for (int i = 0; i < 6; i++) begin
      u_host.write_reg(a[i], 8'hff);
    end
    for (int i = 0; i < 6; i++) begin
      rd_check(a[i], x[i]);
    end
    u_host.write_reg(8'h7f, 8'h00);
  endtask

  task automatic t_rails();
    logic [7:0] cfg [2][3];
    logic [7:0] b;
    logic       e;
    logic       sl;
    logic       lp;
    cfg = '{'{8'hb1, 8'h5c, 8'hf7}, '{8'h42, 8'h3a, 8'h19}};
    for (int s = 0; s < 2; s++) begin
      for (int i = 0; i < 3; i++) begin
        u_host.write_reg(regulator_ctl_pkg::CTL_ADDR[i], cfg[s][i]);
      end
      for (int k = 0; k < 8; k++) begin
        @(posedge clk_sys);
        power_turnoff_event <= k[2];
        standby_req         <= k[1];
        lowpower_req        <= k[0];
        repeat (5) @(posedge clk_sys);
        #1;
        for (int i = 0; i < 3; i++) begin
          b  = cfg[s][i] & regulator_ctl_pkg::CTL_WMASK[i];
          e  = b[4] & !k[2] & !(k[1] & b[5]);
          sl = b[4] & k[2] & b[7];
          lp = e & k[0] & b[6];
          check("en", {7'h0, e}, {7'h0, rail_out[i].en});
          check("sleep", {7'h0, sl}, {7'h0, rail_out[i].sleep});
          check("lowpower", {7'h0, lp}, {7'h0, rail_out[i].lowpower});
          check("code", {4'h0, b[3:0]}, {4'h0, rail_out[i].volt_code});
        end
      end
    end
  endtask

  task automatic t_page();
    logic [3:0]                       pv [4];
    regulator_ctl_pkg::page_kind_type kd [4];
    pv = '{4'h1, 4'h2, 4'h0, 4'h5};
    kd = '{regulator_ctl_pkg::PG_EXTENDED1, regulator_ctl_pkg::PG_EXTENDED2,
           regulator_ctl_pkg::PG_FUNCTIONAL, regulator_ctl_pkg::PG_UNDEFINED};
    for (int i = 0; i < 4; i++) begin
      u_host.write_reg(8'h7f, {4'ha, pv[i]});
      repeat (3) @(posedge clk_sys);
      #1;
      check("page_sel", {4'h0, pv[i]}, {4'h0, page_sel});
      check("page_kind", {6'h0, kd[i]}, {6'h0, page_kind});
      rd_check(8'h80, 8'h00);
      rd_check(regulator_ctl_pkg::CTL_ADDR[0], 8'h42);
    end
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == MAX_CYCLES) begin
      errors++;
      print_verdict();
    end
  end

  initial begin
    errors              = 0;
    total_checks        = 0;
    cycles              = 0;
    rst_b               = 1'b0;
    fuse_cfg            = '{on: 3'b101, code: {4'h9, 4'h6, 4'hb}};
    power_turnoff_event = 1'b0;
    standby_req         = 1'b0;
    lowpower_req        = 1'b0;
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_reset();
    t_mask();
    t_rails();
    t_page();
    print_verdict();
  end
endmodule
